// ===== rtl/srcnt_pkg.sv
// package of the status and rolling counter bank
// assumes: one 25 MHz clock feeds every user of these names
package srcnt_pkg;

    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] ADDR_COUNT = 8'h00; // rolling_tick_counter
    localparam logic [7:0] ADDR_MAIN = 8'h01; // main_device_status
    localparam logic [7:0] ADDR_SUPPLY = 8'h02; // supply_fault_status
    localparam logic [7:0] ADDR_MEMTEMP = 8'h03; // memory_temp_status
    localparam logic [7:0] ADDR_LINK = 8'h04; // link_fault_status

    // ***************************************************
    // field positions
    // ***************************************************
    localparam int MAIN_DSP_BIT = 7; // signal processing summary
    localparam int MAIN_COMM_BIT = 5; // comm_fault_summary
    localparam int MAIN_MEMT_BIT = 4; // memory_temp_fault_summary
    localparam int MAIN_SUP_BIT = 3; // supply summary
    localparam int MAIN_TEST_BIT = 2; // test_active_flag
    localparam int MAIN_RES_BIT = 1; // reset_occurred_flag
    localparam int MAIN_INIT_BIT = 0; // init_pending_flag
    localparam int SUP_LOW_BIT = 7; // low_supply_fault
    localparam int SUP_ANA_BIT = 3; // analog_reg_fault
    localparam int SUP_DIG_BIT = 2; // digital_reg_fault
    localparam int SUP_NVM_BIT = 1; // nvm_reg_fault
    localparam int SUP_SEAL_BIT = 0; // seal_continuity_fault
    localparam int MT_FNVM_BIT = 7; // factory memory fault
    localparam int MT_UNVM_BIT = 6; // user memory fault
    localparam int MT_UREG_BIT = 5; // user register check fault
    localparam int MT_BUSY_BIT = 4; // user memory write busy
    localparam int MT_TEMP_BIT = 2; // temperature_range_fault
    localparam int LINK_MISM_BIT = 7; // readback mismatch

    // ***************************************************
    // reset values and timing
    // ***************************************************
    localparam logic [7:0] COUNT_RESET = 8'h00; // counter after reset
    localparam logic [7:0] BYTE_ZERO = 8'h00; // cleared byte
    localparam int CLK_MHZ = 25; // ref_clk rate
    localparam int PRESCALE_DIV = 1000; // oscillator divide ratio
    localparam int PRESCALE_W = 10; // prescaler width
    localparam int COUNT_W = 8; // rolling counter width
    localparam int SUPPLY_RECOVERY_TIME_US = 10; // supply_recovery_time
    localparam int SUPPLY_RECOVERY_CYC =
        SUPPLY_RECOVERY_TIME_US * CLK_MHZ; // recovery in cycles
    localparam int DATA_VALID_DELAY_US = 1000; // data_valid_delay
    localparam int DATA_VALID_CYC =
        DATA_VALID_DELAY_US * CLK_MHZ; // delay in cycles

    // ***************************************************
    // initialisation states
    // ***************************************************
    typedef enum logic [1:0] {
        INIT_WAIT = 2'b01, // sensor data not yet valid
        INIT_DONE = 2'b10 // sensor data valid
    } srcnt_init_t;

endpackage : srcnt_pkg

// ===== rtl/srcnt_top.sv
// status and rolling counter register bank of a pressure sensor
// assumes: serial front end gives one-cycle read strobes with address
// Function
// RULE1: ten-bit prescaler divides oscillator by thousand
// RULE2: eight-bit counter increments per tick, wraps
// RULE3: all status registers read-only, any interface
// RULE4: main bit7 ORs three signal processing faults
// RULE5: main bit5 mirrors readback mismatch flag
// RULE6: main bit4 ORs memory and temperature faults
// RULE7: main bit3 ORs the five supply faults
// RULE8: main bit2 shows test mode, resets low
// RULE9: main bit1 set by reset, cleared by read
// RULE10: main bit0 clears when sensor data valid
// RULE11: supply bit7 flags low main supply
// RULE12: supply bit3 flags analog regulator fault
// RULE13: supply bit2 flags digital regulator fault
// RULE14: supply bit1 flags memory regulator fault
// RULE15: supply bit0 flags broken edge seal
// RULE16: supply faults share one reloading recovery timer
// RULE17: supply bits clear per report-disable setting
// RULE18: host ignores supply flags during initialisation
// RULE19: memory/temperature faults clear on read or send
// RULE20: link bit7 sets on mismatch, read clears
// RULE21: writes leave counter and flags unchanged
// RULE22: reserved status bits read as zero
`timescale 1ns/1ps
module srcnt_top
    import srcnt_pkg::*;
#(
    parameter int RECOVERY_CYC = SUPPLY_RECOVERY_CYC, // recovery cycles
    parameter int VALID_CYC = DATA_VALID_CYC // init delay cycles
)(
    input wire logic ref_clk, // 25 MHz clock
    input wire logic resetn, // async reset, low active
    input wire logic rd_en, // one-cycle read strobe
    input wire logic [7:0] rd_addr, // register address
    input wire logic tx_main_clr, // transmission carried reset flag
    input wire logic tx_memt_clr, // transmission carried mem faults
    input wire logic tx_link_clr, // transmission carried mismatch
    input wire logic selftest_unfinished, // self-test not done
    input wire logic common_mode_fault, // common mode fault
    input wire logic selftest_fault, // self-test failed
    input wire logic test_enter, // test mode entry pulse
    input wire logic test_exit, // test mode exit pulse
    input wire logic low_supply_mon, // supply below threshold
    input wire logic analog_reg_mon, // analog regulator out of range
    input wire logic digital_reg_mon, // digital regulator bad
    input wire logic nvm_reg_mon, // memory regulator bad
    input wire logic seal_break_mon, // edge seal open
    input wire logic supply_fault_report_off, // lock_control_reg bit
    input wire logic factory_mem_evt, // factory memory fault
    input wire logic user_mem_evt, // user memory fault
    input wire logic user_reg_evt, // user register check fault
    input wire logic user_write_busy, // user memory write running
    input wire logic temperature_evt, // temperature out of range
    input wire logic mismatch_evt, // readback data mismatch
    output logic [7:0] rd_data_q, // read data
    output logic rd_valid_q // read data valid pulse
);

    // ***************************************************
    // state
    // ***************************************************
    logic [PRESCALE_W-1:0] pre_q, pre_d; // prescaler
    logic [COUNT_W-1:0] cnt_q, cnt_d; // rolling counter
    logic test_q, test_d; // test_active_flag
    logic res_q, res_d; // reset_occurred_flag
    logic [4:0] sup_q, sup_d; // supply faults, packed
    logic [31:0] rcv_q, rcv_d; // recovery timer
    logic [3:0] mt_q, mt_d; // sticky memory/temp faults
    logic link_q, link_d; // readback mismatch flag
    logic [31:0] ini_q, ini_d; // data valid timer
    srcnt_init_t st_q, st_d; // init sequencer

    // ***************************************************
    // decode and combinational views
    // ***************************************************
    wire tick = (pre_q == PRESCALE_W'(PRESCALE_DIV - 1)); // [RULE1]
    wire rd_main = rd_en && (rd_addr == ADDR_MAIN); // main read
    wire rd_memt = rd_en && (rd_addr == ADDR_MEMTEMP); // mem read
    wire rd_link = rd_en && (rd_addr == ADDR_LINK); // link read
    wire [4:0] sup_mon = {low_supply_mon, analog_reg_mon,
        digital_reg_mon, nvm_reg_mon, seal_break_mon}; // monitors
    wire sup_any = |sup_mon; // any supply fault now
    wire init_flag = (st_q == INIT_WAIT); // init_pending_flag
    wire dsp_sum = selftest_unfinished | common_mode_fault
        | selftest_fault; // [RULE4]
    wire memt_sum = (|mt_q) | user_write_busy; // [RULE6]
    wire sup_sum = |sup_q; // [RULE7]
    wire [7:0] main_v; // main_device_status view
    wire [7:0] sup_v; // supply_fault_status view
    wire [7:0] mt_v; // memory_temp_status view
    wire [7:0] link_v; // link_fault_status view
    wire [7:0] rd_mux; // selected read value

    // reserved positions stay zero in every view [RULE22]
    assign main_v = 8'(dsp_sum << MAIN_DSP_BIT)
        | 8'(link_q << MAIN_COMM_BIT) // [RULE5]
        | 8'(memt_sum << MAIN_MEMT_BIT)
        | 8'(sup_sum << MAIN_SUP_BIT)
        | 8'(test_q << MAIN_TEST_BIT) // [RULE8]
        | 8'(res_q << MAIN_RES_BIT) // [RULE9]
        | 8'(init_flag << MAIN_INIT_BIT); // [RULE10]
    assign sup_v = 8'(sup_q[4] << SUP_LOW_BIT) // [RULE11]
        | 8'(sup_q[3] << SUP_ANA_BIT) // [RULE12]
        | 8'(sup_q[2] << SUP_DIG_BIT) // [RULE13]
        | 8'(sup_q[1] << SUP_NVM_BIT) // [RULE14]
        | 8'(sup_q[0] << SUP_SEAL_BIT); // [RULE15]
    assign mt_v = 8'(mt_q[3] << MT_FNVM_BIT)
        | 8'(mt_q[2] << MT_UNVM_BIT)
        | 8'(mt_q[1] << MT_UREG_BIT)
        | 8'(user_write_busy << MT_BUSY_BIT)
        | 8'(mt_q[0] << MT_TEMP_BIT);
    assign link_v = 8'(link_q << LINK_MISM_BIT);
    // no write path exists, so no write can alter the bank [RULE21]
    assign rd_mux = (rd_addr == ADDR_COUNT) ? cnt_q : // [RULE3]
        (rd_addr == ADDR_MAIN) ? main_v :
        (rd_addr == ADDR_SUPPLY) ? sup_v :
        (rd_addr == ADDR_MEMTEMP) ? mt_v :
        (rd_addr == ADDR_LINK) ? link_v : BYTE_ZERO;

    // ***************************************************
    // next-state logic
    // ***************************************************
    // prescaler and counter; wrap falls out of 8-bit add
    always_comb
    begin
        pre_d = tick ? '0 : pre_q + 1'b1; // [RULE1]
        cnt_d = tick ? cnt_q + 1'b1 : cnt_q; // [RULE2]
    end

    // test flag: entry wins if both pulses collide
    always_comb
    begin
        test_d = test_q;
        if (test_enter)
        begin
            test_d = 1'b1; // [RULE8]
        end
        else if (test_exit)
        begin
            test_d = 1'b0; // [RULE8]
        end
    end

    // reset flag is only ever set by reset itself
    always_comb
    begin
        res_d = res_q;
        if (rd_main || tx_main_clr)
        begin
            res_d = 1'b0; // [RULE9]
        end
    end

    // supply bits latch; released after recovery runs out
    // with reporting off they follow the monitors only
    always_comb
    begin
        rcv_d = rcv_q;
        sup_d = sup_q;
        if (sup_any)
        begin
            rcv_d = 32'(RECOVERY_CYC); // [RULE16]
        end
        else if (rcv_q != '0)
        begin
            rcv_d = rcv_q - 1'b1; // [RULE16]
        end
        if (supply_fault_report_off)
        begin
            sup_d = sup_mon; // [RULE17]
        end
        else if (!sup_any && rcv_q == 32'd1)
        begin
            sup_d = sup_mon; // [RULE17]
        end
        else
        begin
            sup_d = sup_q | sup_mon; // [RULE11]
        end
    end

    // sticky detail faults: set beats a same-cycle clear
    always_comb
    begin
        mt_d = mt_q;
        link_d = link_q;
        if (rd_memt || tx_memt_clr)
        begin
            mt_d = '0; // [RULE19]
        end
        mt_d = mt_d | {factory_mem_evt, user_mem_evt,
            user_reg_evt, temperature_evt}; // [RULE19]
        if (rd_link || tx_link_clr)
        begin
            link_d = 1'b0; // [RULE20]
        end
        if (mismatch_evt)
        begin
            link_d = 1'b1; // [RULE20]
        end
    end

    // init sequencer waits out the data valid delay
    always_comb
    begin
        ini_d = ini_q;
        st_d = st_q;
        case (st_q)
            INIT_WAIT:
            begin
                ini_d = ini_q + 1'b1;
                if (ini_q == 32'(VALID_CYC - 1))
                begin
                    st_d = INIT_DONE; // [RULE10]
                end
            end
            INIT_DONE:
            begin
                ini_d = ini_q; // hold
            end
            default:
            begin
                st_d = INIT_WAIT; // recover from bad code
            end
        endcase
    end

    // ***************************************************
    // registers
    // ***************************************************
    // timing state
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pre_q <= '0;
            cnt_q <= COUNT_RESET;
            rcv_q <= '0;
            ini_q <= '0;
            st_q <= INIT_WAIT;
        end
        else
        begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            rcv_q <= rcv_d;
            ini_q <= ini_d;
            st_q <= st_d;
        end
    end

    // flags; reset flag comes up set, test flag clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            test_q <= 1'b0;
            res_q <= 1'b1;
            sup_q <= '0;
            mt_q <= '0;
            link_q <= 1'b0;
        end
        else
        begin
            test_q <= test_d;
            res_q <= res_d;
            sup_q <= sup_d;
            mt_q <= mt_d;
            link_q <= link_d;
        end
    end

    // read port, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_data_q <= BYTE_ZERO;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= rd_en ? rd_mux : rd_data_q;
            rd_valid_q <= rd_en;
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_tick_period: assert property ( // [RULE1]
        tick |=> !tick [*8])
        else $error("prescaler tick too close");
    chk_count_step: assert property ( // [RULE2]
        tick |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not step on tick");
    chk_count_hold: assert property ( // [RULE2]
        !tick |=> $stable(cnt_q))
        else $error("counter moved without tick");
    chk_read_value: assert property ( // [RULE3]
        rd_en |=> rd_valid_q && rd_data_q == $past(rd_mux))
        else $error("read data wrong");
    chk_dsp_sum: assert property ( // [RULE4]
        (rd_en && rd_addr == ADDR_MAIN && selftest_fault)
        |=> rd_data_q[MAIN_DSP_BIT])
        else $error("signal processing summary missing");
    chk_link_mirror: assert property ( // [RULE5]
        mismatch_evt |=> main_v[MAIN_COMM_BIT])
        else $error("mismatch not in summary");
    chk_memt_sum: assert property ( // [RULE6]
        temperature_evt |=> main_v[MAIN_MEMT_BIT])
        else $error("memory summary missing");
    chk_sup_sum: assert property ( // [RULE7]
        sup_any && !supply_fault_report_off
        |=> main_v[MAIN_SUP_BIT])
        else $error("supply summary missing");
    chk_test_flag: assert property ( // [RULE8]
        test_exit && !test_enter |=> !test_q)
        else $error("test flag stuck");
    chk_res_clear: assert property ( // [RULE9]
        rd_main |=> !res_q ##1 !res_q)
        else $error("reset flag not cleared by read");
    chk_init_done: assert property ( // [RULE10]
        st_q == INIT_DONE |=> st_q == INIT_DONE)
        else $error("init flag came back");
    chk_sup_latch: assert property ( // [RULE16]
        low_supply_mon && !supply_fault_report_off
        |=> sup_q[4] && rcv_q == 32'(RECOVERY_CYC))
        else $error("supply fault not latched");
    chk_link_sticky: assert property ( // [RULE20]
        mismatch_evt |=> link_q)
        else $error("mismatch lost");

    cov_wrap: cover property (tick && cnt_q == 8'hFF);
    cov_init_end: cover property ($rose(st_q == INIT_DONE));
    cov_sup_release: cover property ($fell(sup_sum));
    cov_mt_clear: cover property (rd_memt && |mt_q);

endmodule : srcnt_top

// ===== test/srcnt_host.sv
// host model: reads the status bank through its read strobe port
// assumes: the bank samples rd_en and rd_addr on the rising ref_clk
`timescale 1ns/1ps
module srcnt_host
    import srcnt_pkg::*;
(
    input wire logic ref_clk, // bank clock
    output logic rd_en, // read strobe
    output logic [7:0] rd_addr, // register address
    input wire logic [7:0] rd_data_q, // read data
    input wire logic rd_valid_q // read data valid
);
    // ***********************************************
    // idle state
    // ***********************************************
    initial
    begin
        rd_en = 1'h0;
        rd_addr = 8'hFF;
    end

    // ***********************************************
    // one read transfer
    // ***********************************************
    // strobe for one cycle, answer taken one cycle later
    task automatic read(input logic [7:0] a, output logic [7:0] d,
        output logic v);
        @(posedge ref_clk);
        rd_en <= 1'h1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        rd_addr <= ~a; // released: no stale address left behind
        // sample mid-cycle, then hand back on a rising edge so that
        // callers drive their next inputs right at the edge
        @(negedge ref_clk);
        v = rd_valid_q;
        d = rd_data_q;
        @(posedge ref_clk);
    endtask : read
endmodule : srcnt_host

// ===== test/tb_top.sv
// testbench of the status and rolling counter bank
// assumes: host model owns the read port, bench drives the monitors
`timescale 1ns/1ps
module tb_top;
    import srcnt_pkg::*;
    // ***********************************************
    // stimulus and observation
    // ***********************************************
    localparam int REC = 5; // short recovery, keeps runs brief
    localparam int VAL = 20; // short init delay
    logic ref_clk = 1'h0; // 25 MHz clock
    logic resetn = 1'h0; // async reset, low active
    logic rd_en; // strobe from host
    logic [7:0] rd_addr; // address from host
    logic [7:0] rd_data_q; // read data
    logic rd_valid_q; // read valid
    logic tx_main_clr = 1'h0; // transmission clears reset flag
    logic tx_memt_clr = 1'h0; // transmission clears memory faults
    logic tx_link_clr = 1'h0; // transmission clears mismatch
    logic [2:0] st = 3'h0; // self-test inputs
    logic test_enter = 1'h0; // test mode entry
    logic test_exit = 1'h0; // test mode exit
    logic [4:0] mon = 5'h00; // supply monitors, seal at bit 0
    logic rpt_off = 1'h0; // report disable setting
    logic [3:0] ev = 4'h0; // memory and temperature events
    logic busy = 1'h0; // user memory write running
    logic mism = 1'h0; // readback mismatch
    int fail_count = 0; // mismatches
    int num_checks = 0; // comparisons

    srcnt_host host (.ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
    srcnt_top #(.RECOVERY_CYC(REC), .VALID_CYC(VAL)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .rd_en(rd_en),
        .rd_addr(rd_addr), .tx_main_clr(tx_main_clr),
        .tx_memt_clr(tx_memt_clr), .tx_link_clr(tx_link_clr),
        .selftest_unfinished(st[0]), .common_mode_fault(st[1]),
        .selftest_fault(st[2]), .test_enter(test_enter),
        .test_exit(test_exit), .low_supply_mon(mon[4]),
        .analog_reg_mon(mon[3]), .digital_reg_mon(mon[2]),
        .nvm_reg_mon(mon[1]), .seal_break_mon(mon[0]),
        .supply_fault_report_off(rpt_off), .factory_mem_evt(ev[0]),
        .user_mem_evt(ev[1]), .user_reg_evt(ev[2]),
        .user_write_busy(busy), .temperature_evt(ev[3]),
        .mismatch_evt(mism), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q));

    // ***********************************************
    // clock, watchdog and shared tasks
    // ***********************************************
    // 40 ns period
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    // the whole run needs about 1300 cycles
    initial
    begin
        repeat (8000) @(posedge ref_clk);
        fail_count++;
        wrap_up();
    end
    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // read one register and compare the whole byte
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.read(a, d, v);
        chk("rd_valid_q", {7'h00, v}, 8'h01);
        chk($sformatf("register %h", a), d, exp);
    endtask : rd

    // ***********************************************
    // scenarios
    // ***********************************************
    // reset flag cleared by a read, or by a transmission
    task automatic t_reset(input logic via_tx);
        @(posedge ref_clk);
        resetn <= 1'h0;
        st <= 3'h1; // self-test not yet run after reset
        cyc(2);
        resetn <= 1'h1;
        rd(ADDR_COUNT, 8'h00);
        if (via_tx)
        begin
            @(posedge ref_clk);
            tx_main_clr <= 1'h1;
            @(posedge ref_clk);
            tx_main_clr <= 1'h0;
        end
        else
            rd(ADDR_MAIN, 8'h83);
        rd(ADDR_MAIN, 8'h81);
        rd(8'h05, 8'h00);
        st <= 3'h0;
    endtask : t_reset
    task automatic t_counter();
        logic [7:0] d0;
        logic [7:0] d1;
        logic v;
        cyc(VAL);
        rd(ADDR_MAIN, 8'h00);
        host.read(ADDR_COUNT, d0, v);
        cyc(997); // second read taken exactly 1000 cycles later
        host.read(ADDR_COUNT, d1, v);
        chk("count step", d1, d0 + 8'h01);
    endtask : t_counter
    task automatic t_selftest();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge ref_clk);
            st <= 3'h1 << i;
            rd(ADDR_MAIN, 8'h80);
        end
        @(posedge ref_clk);
        st <= 3'h0;
    endtask : t_selftest
    // host waits for init to end before trusting these bits
    task automatic t_supply();
        logic [7:0] b;
        for (int i = 0; i < 5; i++)
        begin
            b = (i == 4) ? 8'h80 : 8'h01 << i;
            @(posedge ref_clk);
            mon <= 5'h01 << i;
            cyc(2);
            rd(ADDR_SUPPLY, b);
            rd(ADDR_MAIN, 8'h08);
            @(posedge ref_clk);
            mon <= 5'h00;
            rd(ADDR_SUPPLY, b);
            cyc(REC + 4);
            rd(ADDR_SUPPLY, 8'h00);
        end
        // a second fault restarts the shared timer
        @(posedge ref_clk);
        mon <= 5'h01;
        @(posedge ref_clk);
        mon <= 5'h00;
        cyc(2);
        mon <= 5'h02;
        @(posedge ref_clk);
        mon <= 5'h00;
        @(posedge ref_clk);
        rd(ADDR_SUPPLY, 8'h03);
        cyc(REC + 4);
        rd(ADDR_SUPPLY, 8'h00);
        // reporting off: bits track the monitors
        rpt_off <= 1'h1;
        mon <= 5'h10;
        cyc(2);
        rd(ADDR_SUPPLY, 8'h80);
        mon <= 5'h00;
        cyc(2);
        rd(ADDR_SUPPLY, 8'h00);
        rpt_off <= 1'h0;
    endtask : t_supply
    task automatic t_memtemp();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            ev <= 4'h1 << i;
            @(posedge ref_clk);
            ev <= 4'h0;
            rd(ADDR_MAIN, 8'h10);
            rd(ADDR_MEMTEMP, (i < 3) ? 8'h80 >> i : 8'h04);
            rd(ADDR_MEMTEMP, 8'h00);
        end
        @(posedge ref_clk);
        busy <= 1'h1;
        rd(ADDR_MEMTEMP, 8'h10);
        rd(ADDR_MEMTEMP, 8'h10);
        busy <= 1'h0;
        ev <= 4'h8;
        @(posedge ref_clk);
        ev <= 4'h0;
        tx_memt_clr <= 1'h1;
        @(posedge ref_clk);
        tx_memt_clr <= 1'h0;
        rd(ADDR_MAIN, 8'h00);
    endtask : t_memtemp
    task automatic t_link();
        @(posedge ref_clk);
        mism <= 1'h1;
        @(posedge ref_clk);
        mism <= 1'h0;
        rd(ADDR_MAIN, 8'h20);
        rd(ADDR_LINK, 8'h80);
        rd(ADDR_LINK, 8'h00);
        mism <= 1'h1;
        @(posedge ref_clk);
        mism <= 1'h0;
        tx_link_clr <= 1'h1;
        @(posedge ref_clk);
        tx_link_clr <= 1'h0;
        rd(ADDR_MAIN, 8'h00);
        // mismatch and clear in one cycle: the set must win
        mism <= 1'h1;
        tx_link_clr <= 1'h1;
        @(posedge ref_clk);
        mism <= 1'h0;
        tx_link_clr <= 1'h0;
        rd(ADDR_LINK, 8'h80);
    endtask : t_link
    task automatic t_test_active_flag();
        @(posedge ref_clk);
        test_enter <= 1'h1;
        @(posedge ref_clk);
        test_enter <= 1'h0;
        rd(ADDR_MAIN, 8'h04);
        rd(ADDR_MAIN, 8'h04);
        test_exit <= 1'h1;
        @(posedge ref_clk);
        test_exit <= 1'h0;
        rd(ADDR_MAIN, 8'h00);
    endtask : t_test_active_flag

    // ***********************************************
    // main sequence
    // ***********************************************
    initial
    begin
        t_reset(1'h0);
        t_counter();
        t_selftest();
        t_supply();
        t_memtemp();
        t_link();
        t_test_active_flag();
        t_reset(1'h1);
        wrap_up();
    end
endmodule : tb_top
